/* dv/tb_umd_move_decode.sv */
`timescale 1ns/1ns
module tb_umd_move_decode;
  import umd_pkg::*;
  logic        mclk_i  = 1'b0;
  logic        rst_i   = 1'b1;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic [3:0]  wt      = 4'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  umd_req_s    req_x_o;
  umd_req_s    req_y_o;
  logic        ack_x;
  logic        ack_y;
  logic [31:0] rd_x;
  logic [31:0] rd_y;
  logic [31:0] q;
  logic        e;
  int          errors    = 0;
  int          tests_run = 0;
  int          cycles    = 0;

  always #50 mclk_i = ~mclk_i;

  umd_move_decode i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .req_x_o(req_x_o), .req_y_o(req_y_o), .ack_x_i(ack_x), .ack_y_i(ack_y),
    .rdata_x_i(rd_x), .rdata_y_i(rd_y));
  umd_mem_model i_mem (.mclk_i(mclk_i), .rst_i(rst_i), .wait_i(wt), .req_x_i(req_x_o), .req_y_i(req_y_o),
    .ack_x_o(ack_x), .ack_y_o(ack_y), .rdata_x_o(rd_x), .rdata_y_o(rd_y));

  // ****************************************************************
  // bus and move tasks
  // ****************************************************************
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1)
    begin
      errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    @(posedge mclk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready_o !== 1'b1);
    r       = prdata_o;
    er      = pslverr_o;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [47:0] mk_dir(input logic g, d, l, input logic [6:0] u, input logic [31:0] a);
    mk_dir = {3'h0, 3'h4, g, d, l, u, a};
  endfunction

  // expectations come from the instruction bits, never from the design
  task automatic move(input logic [47:0] ins, input logic sm, input logic [31:0] ea, input logic ep,
                      input logic [6:0] ey);
    logic lw;
    logic pm;
    int   n;
    lw = ins[39] && ea >= NW_LO && ea <= NW_HI;
    pm = (ins[47:45] == 3'h0) ? ins[41] : ins[44];
    apb(1'b1, OFS_STATUS, 32'h0000_0006, q, e);
    apb(1'b1, OFS_INSTR_LO, ins[31:0], q, e);
    apb(1'b1, OFS_INSTR_HI, {16'h0, ins[47:32]}, q, e);
    apb(1'b1, OFS_WDATA_X, ea ^ 32'h5A5A_0000, q, e);
    apb(1'b1, OFS_WDATA_Y, ~ea, q, e);
    // the decode sees the mode bit as it stood before the go write, so set it first
    apb(1'b1, OFS_CTRL, {31'h0, sm}, q, e);
    apb(1'b1, OFS_CTRL, {30'h0, 1'b1, sm}, q, e);
    n = 0;
    while (req_x_o.valid !== 1'b1 && n < 20)
    begin
      @(posedge mclk_i);
      n++;
    end
    chk(req_x_o.addr === ea && req_x_o.reg_num === ins[38:32], "first address or register");
    chk(req_x_o.write === ins[40] && req_x_o.pm_sel === pm, "direction or memory");
    chk(req_x_o.long_word_access === lw, "long word");
    chk(req_x_o.wdata === (ea ^ 32'h5A5A_0000), "first write data");
    chk(req_y_o.valid === ep, "second element presence");
    if (ep)
      chk(req_y_o.addr === ea + 32'h1 && req_y_o.reg_num === ey && req_y_o.wdata === ~ea, "second element");
    // paired moves run with a three-cycle memory wait, so the second request is still open here
    apb(1'b0, OFS_STATUS, 32'h0, q, e);
    chk(q[3] === ep, "second element pending");
    q = 32'h1;
    n = 0;
    while (q[0] !== 1'b0 && n < 20)
    begin
      apb(1'b0, OFS_STATUS, 32'h0, q, e);
      n++;
    end
    // the pending flag drops with the last acknowledge
    chk(q[1] === 1'b1 && q[3] === 1'b0 && q[4] === ins[40], "status after move");
    apb(1'b0, OFS_RDATA_X, 32'h0, q, e);
    if (!ins[40])
      chk(q === ~ea, "first read data");
    apb(1'b0, OFS_RDATA_Y, 32'h0, q, e);
    if (!ins[40] && ep)
      chk(q === ~(ea + 32'h1), "second read data");
  endtask

  task automatic end_of_test;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // hang guard, far above the roughly 160 cycles the tests need
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      errors++;
      end_of_test;
    end
  end

  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    move(mk_dir(1'b0, 1'b0, 1'b1, 7'h05, 32'h0008_0000), 1'b0, 32'h0008_0000, 1'b0, 7'h00);
    wt <= 4'h3;
    move(mk_dir(1'b1, 1'b1, 1'b1, 7'h05, 32'h0004_0010), 1'b1, 32'h0004_0010, 1'b1, 7'h45);
    move(mk_dir(1'b0, 1'b0, 1'b0, 7'h20, 32'h3C00_0100), 1'b1, 32'h3C00_0100, 1'b0, 7'h00);
    apb(1'b1, OFS_INDEX0 + 8'h2C, 32'h0000_0100, q, e);
    // register 0x03 lies outside the generators' own group
    move({3'h5, 1'b1, 3'h3, 1'b0, 1'b0, 7'h03, 32'h0201_0020}, 1'b1, 32'h0201_0120, 1'b1, 7'h43);
    apb(1'b0, OFS_INDEX0 + 8'h2C, 32'h0, q, e);
    chk(q === 32'h0000_0100, "index register changed");
    apb(1'b1, OFS_INSTR_HI, 32'h0000_E000, q, e);
    apb(1'b1, OFS_CTRL, 32'h0000_0002, q, e);
    apb(1'b0, OFS_STATUS, 32'h0, q, e);
    chk(q[2] === 1'b1 && req_x_o.valid === 1'b0, "bad opcode accepted");
    apb(1'b0, 8'h30, 32'h0, q, e);
    chk(e === 1'b1 && q === 32'h0, "unmapped read");
    end_of_test;
  end
endmodule

/* dv/umd_mem_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// memory space behind both element request ports
// ****************************************************************
module umd_mem_model
  import umd_pkg::*;
(
  input  wire logic              mclk_i,    // core clock
  input  wire logic              rst_i,     // sync reset
  input  wire logic [3:0]        wait_i,    // cycles before first ack
  input  wire umd_pkg::umd_req_s req_x_i,   // first element request
  input  wire umd_pkg::umd_req_s req_y_i,   // second element request
  output logic                   ack_x_o,   // first element done
  output logic                   ack_y_o,   // second element done
  output logic [31:0]            rdata_x_o, // first element data
  output logic [31:0]            rdata_y_o  // second element data
);
  logic [3:0] cnt_r;

  // wait counter runs while any request is open
  always_ff @(posedge mclk_i)
  begin
    if (rst_i || !(req_x_i.valid || req_y_i.valid))
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
  end

  // second element answers one cycle late so the acks split
  assign ack_x_o   = req_x_i.valid && cnt_r == wait_i;
  assign ack_y_o   = req_y_i.valid && cnt_r == wait_i + 4'h1;
  // data only valid with the ack, a moving pattern otherwise
  assign rdata_x_o = ack_x_o ? ~req_x_i.addr : {8{cnt_r}};
  assign rdata_y_o = ack_y_o ? ~req_y_i.addr : {8{~cnt_r}};
endmodule

/* hdl/umd_field_decode.sv */
`timescale 1ns/1ns
module umd_field_decode
  import umd_pkg::*;
(
  input  wire logic [umd_pkg::INSTR_W-1:0]  instr_i,     // instruction word
  input  wire logic [31:0]                  idx_val_i,   // selected index value
  input  wire logic                         simd_i,      // pair mode enable
  output logic                              direct_o,    // direct format
  output logic                              legal_o,     // recognised format
  output logic [umd_pkg::IDXSEL_W-1:0]      idx_sel_o,   // index register number
  output logic                              write_o,     // memory write
  output logic                              pm_sel_o,    // program memory
  output logic                              lw_o,        // forced long word
  output logic [31:0]                       addr_x_o,    // first element address
  output logic [31:0]                       addr_y_o,    // second element address
  output logic [umd_pkg::UREG_W-1:0]        ureg_o,      // encoded register
  output logic [umd_pkg::UREG_W-1:0]        cureg_o,     // partner register
  output logic                              pair_o       // second transfer needed
);
  logic [31:0]         imm;
  logic [UREG_W:0]     pr;

  // format recognition
  assign direct_o  = instr_i[FMT_HI:FMT_LO] == FMT_DIRECT && instr_i[SUB_HI:SUB_LO] == SUB_DIRECT;
  assign legal_o   = direct_o || instr_i[FMT_HI:FMT_LO] == FMT_INDIRECT;
  // data memory uses the first generator, program memory the second
  assign idx_sel_o = {instr_i[MSEL_IND_BIT], instr_i[IDX_HI:IDX_LO]};
  assign write_o   = instr_i[DIR_BIT];
  assign pm_sel_o  = direct_o ? instr_i[MSEL_DIR_BIT] : instr_i[MSEL_IND_BIT];
  // address or modifier from split fields
  assign imm       = {instr_i[IMM_UP_HI:IMM_UP_LO], instr_i[IMM_LO_HI:0]};
  assign addr_x_o  = direct_o ? imm : idx_val_i + imm;
  assign addr_y_o  = addr_x_o + 32'h0000_0001;
  // forced long word only inside the normal-word window
  assign lw_o      = instr_i[LW_BIT] && addr_x_o >= NW_LO && addr_x_o <= NW_HI;
  assign ureg_o    = instr_i[UREG_HI:UREG_LO];
  assign pr        = pair_of(ureg_o);
  assign cureg_o   = pr[UREG_W-1:0];
  assign pair_o    = simd_i && pr[UREG_W];
endmodule

/* hdl/umd_move_decode.sv */
`timescale 1ns/1ns
module umd_move_decode
  import umd_pkg::*;
(
  input  wire logic                 mclk_i,        // core clock
  input  wire logic                 rst_i,         // sync reset, active high
  input  wire logic                 psel_i,        // apb select
  input  wire logic                 penable_i,     // apb enable
  input  wire logic                 pwrite_i,      // apb direction
  input  wire logic [7:0]           paddr_i,       // apb byte address
  input  wire logic [31:0]          pwdata_i,      // apb write data
  output logic [31:0]               prdata_o,      // apb read data
  output logic                      pready_o,      // apb ready
  output logic                      pslverr_o,     // apb error
  output umd_pkg::umd_req_s         req_x_o,       // first element request
  output umd_pkg::umd_req_s         req_y_o,       // second element request
  input  wire logic                 ack_x_i,       // first element done
  input  wire logic                 ack_y_i,       // second element done
  input  wire logic [31:0]          rdata_x_i,     // first element read data
  input  wire logic [31:0]          rdata_y_i      // second element read data
);
  import umd_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  umd_state_e          state_r;
  logic [31:0]         instr_lo_r;
  logic [15:0]         instr_hi_r;
  logic                simd_r;
  logic                done_r;
  logic                bad_r;
  logic [31:0]         rdata_x_r;
  logic [31:0]         rdata_y_r;
  logic [31:0]         wdata_x_r;
  logic [31:0]         wdata_y_r;
  logic [31:0]         index_r [NUM_INDEX];
  umd_req_s            req_x_r;
  umd_req_s            req_y_r;
  logic                wr_en;
  logic                rd_en;
  logic                busy;
  logic                go;
  logic [INSTR_W-1:0]  instr;
  logic                dec_direct;
  logic                dec_legal;
  logic [IDXSEL_W-1:0] dec_idx_sel;
  logic                dec_write;
  logic                dec_pm;
  logic                dec_lw;
  logic [31:0]         dec_addr_x;
  logic [31:0]         dec_addr_y;
  logic [UREG_W-1:0]   dec_ureg;
  logic [UREG_W-1:0]   dec_cureg;
  logic                dec_pair;
  logic [31:0]         idx_cur;
  logic                mapped;
  logic [31:0]         rd_word;

  // true when the address hits a given word offset
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = a == ofs;
  endfunction

  // index file occupies sixteen consecutive words
  function automatic logic hit_index(input logic [7:0] a);
    hit_index = a >= OFS_INDEX0 && a < OFS_INDEX0 + 8'(NUM_INDEX * 4) && a[1:0] == 2'h0;
  endfunction

  // ****************************************************************
  // apb slave
  // ****************************************************************
  // zero wait states, so the access phase always ends on its first edge
  assign pready_o  = 1'b1;
  assign wr_en     = psel_i && penable_i && pwrite_i;
  assign rd_en     = psel_i && penable_i && !pwrite_i;
  assign busy      = state_r == ST_XFER;
  assign instr     = {instr_hi_r, instr_lo_r};
  assign go        = wr_en && hit(paddr_i, OFS_CTRL) && pwdata_i[CTRL_GO_BIT] && !busy;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign prdata_o  = rd_en && mapped ? rd_word : RST_WORD;

  // address decode for the read mux and the error answer
  always_comb
  begin
    mapped  = 1'b1;
    rd_word = RST_WORD;
    if (hit(paddr_i, OFS_INSTR_LO))
      rd_word = instr_lo_r;
    else if (hit(paddr_i, OFS_INSTR_HI))
      rd_word = {16'h0000, instr_hi_r};
    else if (hit(paddr_i, OFS_CTRL))
      rd_word = {31'h0000_0000, simd_r};
    else if (hit(paddr_i, OFS_STATUS))
      rd_word = {27'h000_0000, req_x_r.write, req_y_r.valid, bad_r, done_r, busy};
    else if (hit(paddr_i, OFS_ADDR_X))
      rd_word = req_x_r.addr;
    else if (hit(paddr_i, OFS_ADDR_Y))
      rd_word = req_y_r.addr;
    else if (hit(paddr_i, OFS_RDATA_X))
      rd_word = rdata_x_r;
    else if (hit(paddr_i, OFS_RDATA_Y))
      rd_word = rdata_y_r;
    else if (hit(paddr_i, OFS_WDATA_X))
      rd_word = wdata_x_r;
    else if (hit(paddr_i, OFS_WDATA_Y))
      rd_word = wdata_y_r;
    else if (hit_index(paddr_i))
      rd_word = index_r[paddr_i[5:2]];
    else
      mapped = 1'b0;
  end

  // ****************************************************************
  // software registers
  // ****************************************************************
  // instruction is frozen while a move runs so the decode stays stable
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      instr_lo_r <= RST_WORD;
      instr_hi_r <= 16'h0000;
    end
    else if (wr_en && !busy)
    begin
      if (hit(paddr_i, OFS_INSTR_LO))
        instr_lo_r <= pwdata_i;
      if (hit(paddr_i, OFS_INSTR_HI))
        instr_hi_r <= pwdata_i[15:0];
    end
  end

  // mode and write data
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      simd_r    <= 1'b0;
      wdata_x_r <= RST_WORD;
      wdata_y_r <= RST_WORD;
    end
    else if (wr_en && !busy)
    begin
      if (hit(paddr_i, OFS_CTRL))
        simd_r <= pwdata_i[CTRL_SIMD_BIT];
      if (hit(paddr_i, OFS_WDATA_X))
        wdata_x_r <= pwdata_i;
      if (hit(paddr_i, OFS_WDATA_Y))
        wdata_y_r <= pwdata_i;
    end
  end

  // index file, written by software only, never by a move
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INDEX; gi++)
    begin : g_index
      always_ff @(posedge mclk_i)
      begin
        if (rst_i)
          index_r[gi] <= RST_WORD;
        else if (wr_en && !busy && paddr_i == OFS_INDEX0 + 8'(gi * 4))
          index_r[gi] <= pwdata_i;
      end
    end
  endgenerate

  assign idx_cur = index_r[dec_idx_sel];

  // ****************************************************************
  // field decode
  // ****************************************************************
  umd_field_decode u_dec (
    .instr_i   (instr),
    .idx_val_i (idx_cur),
    .simd_i    (simd_r),
    .direct_o  (dec_direct),
    .legal_o   (dec_legal),
    .idx_sel_o (dec_idx_sel),
    .write_o   (dec_write),
    .pm_sel_o  (dec_pm),
    .lw_o      (dec_lw),
    .addr_x_o  (dec_addr_x),
    .addr_y_o  (dec_addr_y),
    .ureg_o    (dec_ureg),
    .cureg_o   (dec_cureg),
    .pair_o    (dec_pair)
  );

  // ****************************************************************
  // transfer sequencing
  // ****************************************************************
  // a move stays busy until every issued element has been acknowledged
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
      state_r <= ST_IDLE;
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (go && dec_legal)
            state_r <= ST_XFER;
        ST_XFER:
          if ((!req_x_r.valid || ack_x_i) && (!req_y_r.valid || ack_y_i))
            state_r <= ST_IDLE;
        default:
          state_r <= ST_IDLE;
      endcase
    end
  end

  // both requests load on the same edge so the elements run in parallel
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      req_x_r <= '0;
      req_y_r <= '0;
    end
    else if (go && dec_legal)
    begin
      req_x_r.valid            <= 1'b1;
      req_x_r.pm_sel           <= dec_pm;
      req_x_r.write            <= dec_write;
      req_x_r.long_word_access <= dec_lw;
      req_x_r.addr             <= dec_addr_x;
      req_x_r.reg_num          <= dec_ureg;
      req_x_r.wdata            <= wdata_x_r;
      req_y_r.valid            <= dec_pair;
      req_y_r.pm_sel           <= dec_pm;
      req_y_r.write            <= dec_write;
      req_y_r.long_word_access <= dec_lw;
      req_y_r.addr             <= dec_addr_y;
      req_y_r.reg_num          <= dec_cureg;
      req_y_r.wdata            <= wdata_y_r;
    end
    else
    begin
      if (ack_x_i)
        req_x_r.valid <= 1'b0;
      if (ack_y_i)
        req_y_r.valid <= 1'b0;
    end
  end

  assign req_x_o = req_x_r;
  assign req_y_o = req_y_r;

  // read data captured on each element's acknowledge
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      rdata_x_r <= RST_WORD;
      rdata_y_r <= RST_WORD;
    end
    else
    begin
      if (req_x_r.valid && ack_x_i && !req_x_r.write)
        rdata_x_r <= rdata_x_i;
      if (req_y_r.valid && ack_y_i && !req_y_r.write)
        rdata_y_r <= rdata_y_i;
    end
  end

  // ****************************************************************
  // status flags
  // ****************************************************************
  // set beats a same-cycle write-one clear so a finishing move is never lost
  always_ff @(posedge mclk_i)
  begin
    if (rst_i)
    begin
      done_r <= 1'b0;
      bad_r  <= 1'b0;
    end
    else
    begin
      if (busy && state_r != ST_IDLE && (!req_x_r.valid || ack_x_i) && (!req_y_r.valid || ack_y_i))
        done_r <= 1'b1;
      else if (wr_en && hit(paddr_i, OFS_STATUS) && pwdata_i[ST_DONE_BIT])
        done_r <= 1'b0;
      if (go && !dec_legal)
        bad_r <= 1'b1;
      else if (wr_en && hit(paddr_i, OFS_STATUS) && pwdata_i[ST_BAD_BIT])
        bad_r <= 1'b0;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_pair_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
    req_y_r.valid && $rose(busy) |-> req_y_r.addr == req_x_r.addr + 32'h0000_0001)
    else $error("second element address is not first plus one");

  chk_parallel_issue: assert property (@(posedge mclk_i) disable iff (rst_i)
    go && dec_legal && dec_pair |=> req_x_r.valid && req_y_r.valid)
    else $error("paired transfers not issued together");

  chk_partner_reg: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(req_y_r.valid) |-> {1'b1, req_y_r.reg_num} == pair_of(req_x_r.reg_num)
      && req_y_r.reg_num != req_x_r.reg_num)
    else $error("second element register is not the partner");

  chk_single_only: assert property (@(posedge mclk_i) disable iff (rst_i)
    go && dec_legal && (!simd_r || dec_ureg < PAIR_BASE || dec_ureg >= PAIR_BASE + PAIR_COUNT) |=> !req_y_r.valid)
    else $error("second transfer issued without a partner");

  chk_dir_sel: assert property (@(posedge mclk_i) disable iff (rst_i)
    go && dec_legal |=> req_x_r.write == $past(instr[DIR_BIT])
      && req_x_r.pm_sel == ($past(dec_direct) ? $past(instr[MSEL_DIR_BIT]) : $past(instr[MSEL_IND_BIT])))
    else $error("direction or memory select wrong");

  chk_long_word: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(busy) && req_x_r.long_word_access |-> instr[LW_BIT] && req_x_r.addr >= NW_LO && req_x_r.addr <= NW_HI)
    else $error("long word forced outside its window");

  chk_reg_field: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy |-> req_x_r.reg_num == instr[UREG_HI:UREG_LO])
    else $error("register number differs from field");

  chk_direct_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy && dec_direct |-> req_x_r.addr == {instr[IMM_UP_HI:IMM_UP_LO], instr[IMM_LO_HI:0]})
    else $error("direct address not assembled from fields");

  chk_index_addr: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy && !dec_direct |-> req_x_r.addr == idx_cur + instr[31:0])
    else $error("indirect address is not index plus modifier");

  chk_index_kept: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy ##1 busy |-> $stable(idx_cur))
    else $error("index register changed during a move");

  chk_format_reject: assert property (@(posedge mclk_i) disable iff (rst_i)
    go && !dec_legal |=> !busy && bad_r && !req_x_r.valid)
    else $error("unrecognised opcode was executed");

  chk_move_ends: assert property (@(posedge mclk_i) disable iff (rst_i)
    busy && ack_x_i && (ack_y_i || !req_y_r.valid) |=> !busy && done_r)
    else $error("move did not end after both acknowledges");
endmodule

/* hdl/umd_pkg.sv */
package umd_pkg;

  // ****************************************************************
  // instruction field positions
  // ****************************************************************
  localparam int INSTR_W      = 48;
  localparam int FMT_HI       = 47;
  localparam int FMT_LO       = 45;
  localparam int SUB_HI       = 44;
  localparam int SUB_LO       = 42;
  localparam int MSEL_DIR_BIT = 41;
  localparam int MSEL_IND_BIT = 44;
  localparam int DIR_BIT      = 40;
  localparam int LW_BIT       = 39;
  localparam int UREG_HI      = 38;
  localparam int UREG_LO      = 32;
  localparam int IDX_HI       = 43;
  localparam int IDX_LO       = 41;
  localparam int IMM_UP_HI    = 31;
  localparam int IMM_UP_LO    = 24;
  localparam int IMM_LO_HI    = 23;
  localparam int UREG_W       = UREG_HI - UREG_LO + 1;
  localparam int IDXSEL_W     = 4;

  localparam logic [2:0] FMT_DIRECT   = 3'h0;
  localparam logic [2:0] SUB_DIRECT   = 3'h4;
  localparam logic [2:0] FMT_INDIRECT = 3'h5;

  // ****************************************************************
  // register map (byte offsets) and control bits
  // ****************************************************************
  localparam logic [7:0] OFS_INSTR_LO = 8'h00;
  localparam logic [7:0] OFS_INSTR_HI = 8'h04;
  localparam logic [7:0] OFS_CTRL     = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_ADDR_X   = 8'h10;
  localparam logic [7:0] OFS_ADDR_Y   = 8'h14;
  localparam logic [7:0] OFS_RDATA_X  = 8'h18;
  localparam logic [7:0] OFS_RDATA_Y  = 8'h1C;
  localparam logic [7:0] OFS_WDATA_X  = 8'h20;
  localparam logic [7:0] OFS_WDATA_Y  = 8'h24;
  localparam logic [7:0] OFS_INDEX0   = 8'h40;
  localparam int NUM_INDEX    = 16;

  localparam int CTRL_SIMD_BIT = 0;
  localparam int CTRL_GO_BIT   = 1;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_DONE_BIT   = 1;
  localparam int ST_BAD_BIT    = 2;
  localparam int ST_PAIR_BIT   = 3;
  localparam int ST_WRITE_BIT  = 4;

  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ****************************************************************
  // complementary register pairing and normal-word window
  // ****************************************************************
  localparam logic [UREG_W-1:0] PAIR_BASE  = 7'h00;
  localparam logic [UREG_W-1:0] PAIR_COUNT = 7'h10;
  localparam logic [UREG_W-1:0] PAIR_OFS   = 7'h40;
  localparam logic [31:0]       NW_LO      = 32'h0004_0000;
  localparam logic [31:0]       NW_HI      = 32'h0007_FFFF;

  // partner of a register, valid flag in the top bit
  function automatic logic [UREG_W:0] pair_of(input logic [UREG_W-1:0] ureg);
    logic [UREG_W-1:0] rel;
    rel = ureg - PAIR_BASE;
    if (ureg >= PAIR_BASE && rel < PAIR_COUNT)
      pair_of = {1'b1, ureg + PAIR_OFS};
    else
      pair_of = {1'b0, ureg};
  endfunction

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_XFER = 2'b10
  } umd_state_e;

  // one element's memory transfer request
  typedef struct packed {
    logic              valid;
    logic              pm_sel;
    logic              write;
    logic              long_word_access;
    logic [31:0]       addr;
    logic [UREG_W-1:0] reg_num;
    logic [31:0]       wdata;
  } umd_req_s;

endpackage
